/* hdl/fault_search.sv */
`timescale 1ns/1ps
// combinational wrap-around search for the next node holding an entry
module fault_search
    import fault_table_pkg::*;
(
    // search request and answer
    table_link_if.finder lk
);
    // lowest set bit at or after start, else lowest set bit overall
    function automatic logic [NODE_W:0] find_from(input logic [NODES-1:0] m, input logic [NODE_W-1:0] s);
        logic [NODE_W:0] r;
        r = '0;
        for (int i = NODES - 1; i >= 0; i--)
        begin
            if (m[i])
                r = {1'b1, NODE_W'(i)};
        end
        for (int i = NODES - 1; i >= 0; i--)
        begin
            if (m[i] && (NODE_W'(i) >= s))
                r = {1'b1, NODE_W'(i)};
        end
        return r;
    endfunction

    logic [NODE_W:0] hit; // found flag and index

    // search is purely combinational so commands answer in one cycle
    always_comb
    begin
        hit = find_from(lk.mask, lk.start);
    end
    assign lk.found = hit[NODE_W];
    assign lk.idx = hit[NODE_W-1:0];
    // no clock here: the search result is checked in the table core, where it is used
endmodule

/* hdl/fault_table_pkg.sv */
package fault_table_pkg;
    // table geometry
    localparam int NODES = 64;
    localparam int NODE_W = 6;
    localparam int CODE_W = 8;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    // fault code values, higher value wins
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_SCAN = 8'h01;
    localparam logic [7:0] CODE_TMO_FIRST = 8'h02;
    localparam logic [7:0] CODE_TMO_LAST = 8'h0a;
    localparam logic [7:0] CODE_NO_EXPL = 8'h0b;
    localparam logic [7:0] CODE_NO_POLL = 8'h0c;
    localparam logic [7:0] CODE_CONS_SIZE = 8'h0d;
    localparam logic [7:0] CODE_PROD_SIZE = 8'h0e;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    // reset values
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [5:0] NODE_ZERO = 6'h00;
    localparam logic [5:0] NODE_ONE = 6'h01;
endpackage

/* hdl/node_fault_table.sv */
`timescale 1ns/1ps
// per-node fault table with a single-entry window for the host
module node_fault_table
    import fault_table_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF // cycles per millisecond
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // host command bits
    input wire logic show_first_fault_cmd,
    input wire logic show_next_fault_cmd,
    input wire logic clear_faults_cmd,
    // fault reports from the polling engine
    input wire logic rpt_valid,
    input wire logic [5:0] rpt_node,
    input wire logic [7:0] rpt_code,
    input wire logic [15:0] rpt_data,
    // polled command events
    input wire logic poll_sent,
    input wire logic [5:0] poll_node,
    // host display words
    output logic [15:0] fault_view_code_word,
    output logic [15:0] fault_view_data_word
);
    table_link_if lk ();

    // command synchronisers: three stages, change accepted when last two agree
    logic [2:0] first_s_q, first_s_d;
    logic [2:0] next_s_q, next_s_d;
    logic [2:0] clr_s_q, clr_s_d;
    logic first_lvl_q, first_lvl_d; // accepted levels
    logic next_lvl_q, next_lvl_d;
    logic clr_lvl_q, clr_lvl_d;
    logic first_rise, next_rise, clr_rise; // one-cycle command pulses

    // table state
    logic [CODE_W-1:0] code_q [NODES], code_d [NODES]; // fault code per node
    logic [WORD_W-1:0] data_q [NODES], data_d [NODES]; // fault data per node
    logic [NODE_W-1:0] cursor_q, cursor_d; // displayed node
    logic [WORD_W-1:0] vcode_q, vcode_d; // code word output register
    logic [WORD_W-1:0] vdata_q, vdata_d; // data word output register

    // assertion helpers
    logic [NODE_W-1:0] mon_node_q; // rpt_node seen last cycle, whether or not rpt_valid was set
    logic [CODE_W-1:0] mon_code_q; // its code before the update
    logic mon_clr_q; // clear happened last cycle

    // accepted-level update rule shared by all commands
    function automatic logic settle(input logic [2:0] s, input logic lvl);
        return (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    // synchroniser next values
    always_comb
    begin
        first_s_d = {first_s_q[1:0], show_first_fault_cmd};
        next_s_d = {next_s_q[1:0], show_next_fault_cmd};
        clr_s_d = {clr_s_q[1:0], clear_faults_cmd};
        first_lvl_d = settle(first_s_q, first_lvl_q);
        next_lvl_d = settle(next_s_q, next_lvl_q);
        clr_lvl_d = settle(clr_s_q, clr_lvl_q);
        first_rise = first_lvl_d && !first_lvl_q;
        next_rise = next_lvl_d && !next_lvl_q;
        clr_rise = clr_lvl_d && !clr_lvl_q;
    end

    // synchroniser registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            first_s_q <= '0;
            next_s_q <= '0;
            clr_s_q <= '0;
            first_lvl_q <= 1'b0;
            next_lvl_q <= 1'b0;
            clr_lvl_q <= 1'b0;
        end
        else
        begin
            first_s_q <= first_s_d;
            next_s_q <= next_s_d;
            clr_s_q <= clr_s_d;
            first_lvl_q <= first_lvl_d;
            next_lvl_q <= next_lvl_d;
            clr_lvl_q <= clr_lvl_d;
        end
    end

    // helpers: search and scan timing
    fault_search u_search (
        .lk (lk.finder)
    );
    scan_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst_b (rst_b),
        .lk (lk.timer)
    );

    // poll events pass straight on, same clock
    assign lk.poll_go = poll_sent;
    assign lk.poll_node = poll_node;

    // entry mask: any non-zero code counts as an entry
    always_comb
    begin
        for (int i = 0; i < NODES; i++)
            lk.mask[i] = (code_q[i] != CODE_NONE);
        // show-first searches from zero, show-next from the node after the cursor; if both rise together, the search starts after the cursor
        lk.start = next_rise ? (cursor_q + NODE_ONE) : NODE_ZERO;
    end

    // table next values
    always_comb
    begin
        code_d = code_q;
        data_d = data_q;
        // clear empties the table; updates below still land, so a same-cycle event survives
        if (clr_rise)
        begin
            for (int i = 0; i < NODES; i++)
            begin
                code_d[i] = CODE_NONE;
                data_d[i] = WORD_ZERO;
            end
        end
        // scan time refreshes only entries with nothing worse to show
        if (lk.scan_valid && (code_q[lk.scan_node] <= CODE_SCAN || clr_rise))
        begin
            code_d[lk.scan_node] = CODE_SCAN;
            data_d[lk.scan_node] = lk.scan_ms;
        end
        // reported fault replaces only a lower code; report beats scan for the same node
        if (rpt_valid && (rpt_code > code_q[rpt_node] || (clr_rise && rpt_code != CODE_NONE)))
        begin
            code_d[rpt_node] = rpt_code;
            // size errors: reported size high byte, configured size low byte; else don't care
            data_d[rpt_node] = rpt_data;
        end
    end

    // table registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NODES; i++)
            begin
                code_q[i] <= CODE_NONE;
                data_q[i] <= WORD_ZERO;
            end
        end
        else
        begin
            code_q <= code_d;
            data_q <= data_d;
        end
    end

    // cursor and window next values
    always_comb
    begin
        cursor_d = cursor_q;
        // cursor stays put when nothing is found
        if ((first_rise || next_rise) && lk.found)
            cursor_d = lk.idx;
        // window follows the live entry at the cursor
        vcode_d = {code_q[cursor_q], {(BYTE_W - NODE_W){1'b0}}, cursor_q};
        vdata_d = data_q[cursor_q];
    end

    // cursor and window registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cursor_q <= NODE_ZERO;
            vcode_q <= WORD_ZERO;
            vdata_q <= WORD_ZERO;
        end
        else
        begin
            cursor_q <= cursor_d;
            vcode_q <= vcode_d;
            vdata_q <= vdata_d;
        end
    end
    assign fault_view_code_word = vcode_q;
    assign fault_view_data_word = vdata_q;

    // assertion helper registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mon_node_q <= NODE_ZERO;
            mon_code_q <= CODE_NONE;
            mon_clr_q <= 1'b1;
        end
        else
        begin
            mon_node_q <= rpt_node;
            mon_code_q <= code_q[rpt_node];
            mon_clr_q <= clr_rise;
        end
    end

    // show-first lands on the found node next cycle
    first_cursor_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        first_rise && lk.found |=> cursor_q == $past(lk.idx));
    // show-first searches from address zero unless show-next rises in the same cycle; the check does not exclude that case
    first_from_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        first_rise |-> lk.start == NODE_ZERO && (!lk.found || lk.mask[lk.idx]));
    // search finds something exactly when some entry exists, and it holds an entry
    found_has_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lk.found == (lk.mask != '0) && (!lk.found || lk.mask[lk.idx]));
    // show-next lands on the found node, which holds an entry
    next_cursor_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        next_rise && lk.found |-> lk.mask[lk.idx] ##1 cursor_q == $past(lk.idx));
    // clear without a competing event leaves the table empty
    clear_empties_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clr_rise && !rpt_valid && !lk.scan_valid |=> lk.mask == '0);
    // code word low byte carries the displayed address
    view_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        1'b1 |=> fault_view_code_word[BYTE_W-1:0] == {2'b00, $past(cursor_q)});
    // code word high byte shows the cursor entry's code one cycle later
    view_code_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $stable(cursor_q) && !rpt_valid && !lk.scan_valid && !clr_rise
        |=> fault_view_code_word[WORD_W-1:BYTE_W] == $past(code_q[cursor_q]));
    // data word shows the cursor entry's data one cycle later
    view_data_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        1'b1 |=> fault_view_data_word == $past(data_q[cursor_q]));
    // codes never fall except by a clear
    no_demote_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !mon_clr_q |-> code_q[mon_node_q] >= mon_code_q);
    // a scan result on a quiet entry becomes code 1 with the time
    scan_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lk.scan_valid && code_q[lk.scan_node] <= CODE_SCAN && !rpt_valid
        |=> code_q[$past(lk.scan_node)] == CODE_SCAN && data_q[$past(lk.scan_node)] == $past(lk.scan_ms));
    // a pulse needs the pin seen high twice, and a held bit gives no second pulse
    single_shot_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        first_rise |-> ($past(show_first_fault_cmd, 2) && $past(show_first_fault_cmd, 3)) ##1 !first_rise);
endmodule

/* hdl/scan_timer.sv */
`timescale 1ns/1ps
// measures poll-to-poll time per node in milliseconds
module scan_timer
    import fault_table_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // poll events and measured times
    table_link_if.timer lk
);
    logic [31:0] div_q, div_d; // millisecond divider
    logic [WORD_W-1:0] now_q, now_d; // free-running millisecond count
    logic [WORD_W-1:0] stamp_q [NODES], stamp_d [NODES]; // last poll time per node
    logic [NODES-1:0] seen_q, seen_d; // node polled at least once
    logic sv_q, sv_d; // scan result valid
    logic [NODE_W-1:0] sn_q, sn_d; // scan result node
    logic [WORD_W-1:0] sm_q, sm_d; // scan result value

    // next state: each node keeps its own stamp, so polls may overlap freely
    always_comb
    begin
        div_d = div_q + 32'h1;
        now_d = now_q;
        stamp_d = stamp_q;
        seen_d = seen_q;
        sv_d = 1'b0;
        sn_d = sn_q;
        sm_d = sm_q;
        if (div_q >= 32'(MS_CYCLES - 1))
        begin
            div_d = '0;
            now_d = now_q + 16'h1; // wraps, difference stays right below 65 s
        end
        if (lk.poll_go)
        begin
            stamp_d[lk.poll_node] = now_q;
            seen_d[lk.poll_node] = 1'b1;
            sv_d = seen_q[lk.poll_node]; // first poll has no interval yet
            sn_d = lk.poll_node;
            sm_d = now_q - stamp_q[lk.poll_node];
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_q <= '0;
            now_q <= WORD_ZERO;
            for (int i = 0; i < NODES; i++)
                stamp_q[i] <= WORD_ZERO;
            seen_q <= '0;
            sv_q <= 1'b0;
            sn_q <= NODE_ZERO;
            sm_q <= WORD_ZERO;
        end
        else
        begin
            div_q <= div_d;
            now_q <= now_d;
            stamp_q <= stamp_d;
            seen_q <= seen_d;
            sv_q <= sv_d;
            sn_q <= sn_d;
            sm_q <= sm_d;
        end
    end
    assign lk.scan_valid = sv_q;
    assign lk.scan_node = sn_q;
    assign lk.scan_ms = sm_q;

    // a repeat poll yields a result next cycle for that node
    repeat_poll_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lk.poll_go && seen_q[lk.poll_node] |=> sv_q && (sn_q == $past(lk.poll_node)));
    // a first poll yields no result
    first_poll_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        lk.poll_go && !seen_q[lk.poll_node] |=> !sv_q);
endmodule

/* hdl/table_link_if.sv */
`timescale 1ns/1ps
// carries search and scan-timer traffic between the table core and its helpers
interface table_link_if;
    import fault_table_pkg::*;
    logic [NODES-1:0] mask; // nodes holding an entry
    logic [NODE_W-1:0] start; // search start address
    logic found; // some node at/after start (wrapping) has an entry
    logic [NODE_W-1:0] idx; // that node
    logic poll_go; // polled command sent
    logic [NODE_W-1:0] poll_node; // its target
    logic scan_valid; // a new scan time measured
    logic [NODE_W-1:0] scan_node; // for this node
    logic [WORD_W-1:0] scan_ms; // milliseconds between polls
    modport finder (input mask, input start, output found, output idx);
    modport timer (input poll_go, input poll_node, output scan_valid, output scan_node, output scan_ms);
    modport core (output mask, output start, input found, input idx,
                  output poll_go, output poll_node, input scan_valid, input scan_node, input scan_ms);
endinterface

/* tb/host_model.sv */
`timescale 1ns/1ps
// stands in for the host program and the polling engine feeding the table
module host_model (
    // clock
    input wire logic sys_clk,
    // host command bits
    output logic show_first_fault_cmd,
    output logic show_next_fault_cmd,
    output logic clear_faults_cmd,
    // fault reports
    output logic rpt_valid,
    output logic [5:0] rpt_node,
    output logic [7:0] rpt_code,
    output logic [15:0] rpt_data,
    // polled command events
    output logic poll_sent,
    output logic [5:0] poll_node
);
    // everything idle at time zero
    initial
    begin
        {show_first_fault_cmd, show_next_fault_cmd, clear_faults_cmd} = 3'h0;
        {rpt_valid, rpt_node, rpt_code, rpt_data} = 31'h0;
        {poll_sent, poll_node} = 7'h00;
    end

    // raises one command bit (0 first, 1 next, 2 clear), never two at once
    task automatic cmd(input int which, input int hold);
        @(negedge sys_clk);
        show_first_fault_cmd = (which == 0);
        show_next_fault_cmd = (which == 1);
        clear_faults_cmd = (which == 2);
        repeat (hold) @(negedge sys_clk);
        {show_first_fault_cmd, show_next_fault_cmd, clear_faults_cmd} = 3'h0;
        // low long enough for the synchroniser and the view to settle
        repeat (8) @(negedge sys_clk);
    endtask

    // one-cycle fault report; released lines show the inverse of their last value
    task automatic report(input logic [5:0] n, input logic [7:0] c, input logic [15:0] d);
        @(negedge sys_clk);
        rpt_valid = 1'b1;
        rpt_node = n;
        rpt_code = c;
        rpt_data = d;
        @(negedge sys_clk);
        rpt_valid = 1'b0;
        rpt_node = ~rpt_node;
        rpt_code = ~rpt_code;
        rpt_data = ~rpt_data;
    endtask

    // one-cycle polled command event
    task automatic poll(input logic [5:0] n);
        @(negedge sys_clk);
        poll_sent = 1'b1;
        poll_node = n;
        @(negedge sys_clk);
        poll_sent = 1'b0;
        poll_node = ~poll_node;
    endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
// self-checking bench for the node fault table
module testbench
    import fault_table_pkg::*;
;
    localparam int MSC = 10; // short millisecond for simulation
    // one table case: two reports to one node and the view they should leave
    typedef struct packed {
        logic [5:0] node;
        logic [7:0] c1;
        logic [15:0] d1;
        logic [7:0] c2;
        logic [15:0] d2;
        logic [7:0] ec;
        logic [15:0] ed;
    } row_t;
    localparam row_t ROWS [7] = '{
        '{6'h03, 8'h02, 16'h1111, 8'h05, 16'h2222, 8'h05, 16'h2222},
        '{6'h0a, 8'h06, 16'h3333, 8'h04, 16'h4444, 8'h06, 16'h3333},
        '{6'h3f, 8'h07, 16'h0000, 8'h08, 16'h0000, 8'h08, 16'h0000},
        '{6'h00, 8'h09, 16'h0000, 8'h03, 16'h0000, 8'h09, 16'h0000},
        '{6'h1f, 8'h0a, 16'h0000, 8'h0b, 16'h0000, 8'h0b, 16'h0000},
        '{6'h28, 8'h0d, 16'h2010, 8'h0c, 16'h5555, 8'h0d, 16'h2010},
        '{6'h11, 8'h01, 16'h0007, 8'h0e, 16'h0a05, 8'h0e, 16'h0a05}
    };
    // clock, reset and design pins
    logic sys_clk;
    logic rst_b;
    logic show_first_fault_cmd;
    logic show_next_fault_cmd;
    logic clear_faults_cmd;
    logic rpt_valid;
    logic [5:0] rpt_node;
    logic [7:0] rpt_code;
    logic [15:0] rpt_data;
    logic poll_sent;
    logic [5:0] poll_node;
    logic [15:0] fault_view_code_word;
    logic [15:0] fault_view_data_word;
    int n_mismatch;
    int samples_checked;

    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    node_fault_table #(.MS_CYCLES(MSC)) i_dut (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .show_first_fault_cmd(show_first_fault_cmd),
        .show_next_fault_cmd(show_next_fault_cmd),
        .clear_faults_cmd(clear_faults_cmd),
        .rpt_valid(rpt_valid),
        .rpt_node(rpt_node),
        .rpt_code(rpt_code),
        .rpt_data(rpt_data),
        .poll_sent(poll_sent),
        .poll_node(poll_node),
        .fault_view_code_word(fault_view_code_word),
        .fault_view_data_word(fault_view_data_word)
    );

    host_model i_host (
        .sys_clk(sys_clk),
        .show_first_fault_cmd(show_first_fault_cmd),
        .show_next_fault_cmd(show_next_fault_cmd),
        .clear_faults_cmd(clear_faults_cmd),
        .rpt_valid(rpt_valid),
        .rpt_node(rpt_node),
        .rpt_code(rpt_code),
        .rpt_data(rpt_data),
        .poll_sent(poll_sent),
        .poll_node(poll_node)
    );

    // compares one word and reports a mismatch at once
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // prints the verdict and ends the run
    task automatic summarize();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        n_mismatch = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("code word in reset", WORD_ZERO, fault_view_code_word);
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        chk("code word after reset", WORD_ZERO, fault_view_code_word);
        chk("data word after reset", WORD_ZERO, fault_view_data_word);
        // table cases: every code, priority both ways, show-first on a lone entry
        for (int i = 0; i < 7; i++)
        begin
            i_host.cmd(2, 4);
            i_host.report(ROWS[i].node, ROWS[i].c1, ROWS[i].d1);
            i_host.report(ROWS[i].node, ROWS[i].c2, ROWS[i].d2);
            i_host.cmd(0, 4);
            chk("code word", {ROWS[i].ec, 2'b00, ROWS[i].node}, fault_view_code_word);
            if (ROWS[i].ec >= CODE_CONS_SIZE)
                chk("size data word", ROWS[i].ed, fault_view_data_word);
        end
        // lowest first, walk upward, wrap, held bit acts once
        i_host.cmd(2, 4);
        i_host.report(6'h32, 8'h03, 16'h0000);
        i_host.report(6'h05, 8'h03, 16'h0000);
        i_host.report(6'h14, 8'h03, 16'h0000);
        i_host.cmd(0, 4);
        chk("first node", 16'h0305, fault_view_code_word);
        i_host.cmd(1, 20);
        chk("next after long hold", 16'h0314, fault_view_code_word);
        i_host.cmd(1, 4);
        chk("next node", 16'h0332, fault_view_code_word);
        i_host.cmd(1, 4);
        chk("wrapped node", 16'h0305, fault_view_code_word);
        i_host.cmd(2, 4);
        chk("cleared entry", 16'h0005, fault_view_code_word);
        // overlapping polls: node 12 every 50 cycles, node 13 every 30
        i_host.poll(6'h0c);
        repeat (8) @(negedge sys_clk);
        i_host.poll(6'h0d);
        repeat (28) @(negedge sys_clk);
        i_host.poll(6'h0d);
        repeat (8) @(negedge sys_clk);
        i_host.poll(6'h0c);
        i_host.cmd(0, 4);
        chk("scan code node 12", {CODE_SCAN, 8'h0c}, fault_view_code_word);
        chk("scan ms node 12", 16'd50 / MSC, fault_view_data_word);
        i_host.cmd(1, 4);
        chk("scan code node 13", {CODE_SCAN, 8'h0d}, fault_view_code_word);
        chk("scan ms node 13", 16'd30 / MSC, fault_view_data_word);
        // a real fault is not overwritten by a later scan time
        i_host.report(6'h0c, 8'h04, 16'h0404);
        repeat (20) @(negedge sys_clk);
        i_host.poll(6'h0c);
        i_host.cmd(0, 4);
        chk("fault kept over scan", 16'h040c, fault_view_code_word);
        summarize();
    end
endmodule
